//--- src/lpm_defs.svh
`ifndef LPM_DEFS_SVH
`define LPM_DEFS_SVH

`define LPM_ADDR_W        4
`define LPM_DATA_W        32
`define LPM_OFF_CTRL      4'h0
`define LPM_OFF_STATUS    4'h1
`define LPM_OFF_MASK      4'h2
`define LPM_OFF_STATE     4'h3
`define LPM_OFF_WAKEEN    4'h4

`define LPM_CTRL_DET_EN   0
`define LPM_CTRL_FALL     1
`define LPM_CTRL_RISE     2
`define LPM_CTRL_STOP_LP  3
`define LPM_CTRL_DEEP     4
`define LPM_CTRL_STDBY    5
`define LPM_CTRL_W        6
`define LPM_CTRL_RST      6'h00

`define LPM_ST_DET_FALL   0
`define LPM_ST_DET_RISE   1
`define LPM_ST_WOKE_STOP  2
`define LPM_ST_WOKE_STDBY 3
`define LPM_ST_W          4
`define LPM_ST_RST        4'h0

`define LPM_EXT_LINES     16
`define LPM_WAKEEN_RST    16'hffff
`define LPM_STATE_W       3
`define LPM_PERIOD_NS     5
`define LPM_BOOT_NS       100
`define LPM_BOOT_CYC      ((`LPM_BOOT_NS + `LPM_PERIOD_NS - 1) / `LPM_PERIOD_NS)
`define LPM_BOOT_W        8

`endif

//--- src/lpm_pkg.sv
package lpm_pkg;
    `include "lpm_defs.svh"

    typedef enum logic [2:0] {
        LPM_RUN     = 3'b000,
        LPM_SLEEP   = 3'b001,
        LPM_STOP    = 3'b010,
        LPM_STANDBY = 3'b011,
        LPM_BOOT    = 3'b100
    } lpm_state_e;

    typedef enum logic [1:0] {
        LPM_REG_MAIN = 2'b00,
        LPM_REG_LOW  = 2'b01,
        LPM_REG_OFF  = 2'b10
    } lpm_reg_mode_e;

    typedef struct packed {
        logic       core_clk_en;
        logic       periph_clk_en;
        logic       fast_osc_en;
        logic       core_rst_n;
        logic [1:0] reg_mode;
    } lpm_power_s;
endpackage : lpm_pkg

//--- src/lpm_sync.sv
`timescale 1ns/100ps
module lpm_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            s1_reg <= '0;
            s2_reg <= '0;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
        end
    end

    assign dout = s2_reg;
endmodule : lpm_sync

//--- src/lpm_ctrl.sv
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`include "lpm_defs.svh"
// Functional notes
// - Chip held in reset whenever supply is below power-down threshold.
// - Detector raises interrupt on falling, rising, or both threshold crossings.
// - Regulator: main in run, main or low-power in stop, off in standby.
// - Regulator enabled after reset, disabled in standby, core state lost.
// - Sleep halts only processor clock; any interrupt or event wakes it.
// - Stop halts core clocks, fast oscillators and PLL, keeps state.
// - Stop regulator mode, normal or low-power, chosen by software.
// - Stop exits on external line, detector output or alarm.
// - Standby powers off core domain, PLL and fast oscillators.
// - Standby exits on reset pin, watchdog reset, wake rising edge, alarm.
// - Low-power modes never stop real-time counter, watchdog or their clocks.
module lpm_ctrl
    import lpm_pkg::*;
(
    input  wire logic                          clock,
    input  wire logic                          rstn,
    input  wire logic [`LPM_ADDR_W-1:0]        addr,
    input  wire logic [`LPM_DATA_W-1:0]        wdata,
    input  wire logic                          wr,
    input  wire logic                          rd,
    output logic      [`LPM_DATA_W-1:0]        rdata,
    output logic                               irq,
    input  wire logic                          supply_ok,
    input  wire logic                          supply_above_threshold,
    input  wire logic                          wait_req,
    input  wire logic                          core_event,
    input  wire logic [`LPM_EXT_LINES-1:0]     external_event_lines,
    input  wire logic                          alarm,
    input  wire logic                          wake_pin,
    input  wire logic                          reset_pin_n,
    input  wire logic                          independent_watchdog_rst,
    output lpm_power_s                         power,
    output logic                               slow_domain_en
);
    logic                            por_ok;
    logic                            above_s;
    logic [`LPM_EXT_LINES-1:0]       ext_s;
    logic                            alarm_s;
    logic                            wake_s;
    logic                            pin_n_s;
    logic                            wdg_s;

    lpm_sync #(.W(1)) u_sync_por (.clock(clock), .rstn(rstn), .din(supply_ok), .dout(por_ok));
    lpm_sync #(.W(1)) u_sync_det (.clock(clock), .rstn(rstn), .din(supply_above_threshold), .dout(above_s));
    lpm_sync #(.W(`LPM_EXT_LINES)) u_sync_ext (.clock(clock), .rstn(rstn), .din(external_event_lines),
                                               .dout(ext_s));
    lpm_sync #(.W(1)) u_sync_alm (.clock(clock), .rstn(rstn), .din(alarm), .dout(alarm_s));
    lpm_sync #(.W(1)) u_sync_wk  (.clock(clock), .rstn(rstn), .din(wake_pin), .dout(wake_s));
    lpm_sync #(.W(1)) u_sync_pin (.clock(clock), .rstn(rstn), .din(reset_pin_n), .dout(pin_n_s));
    lpm_sync #(.W(1)) u_sync_wdg (.clock(clock), .rstn(rstn), .din(independent_watchdog_rst), .dout(wdg_s));

    logic [`LPM_CTRL_W-1:0]          ctrl_reg,   ctrl_next;
    logic [`LPM_ST_W-1:0]            status_reg, status_next;
    logic [`LPM_ST_W-1:0]            mask_reg,   mask_next;
    logic [`LPM_EXT_LINES-1:0]       wakeen_reg, wakeen_next;
    logic [`LPM_DATA_W-1:0]          rdata_next;
    logic                            above_d_reg, above_d_next;
    logic                            wake_d_reg,  wake_d_next;
    logic [`LPM_EXT_LINES-1:0]       ext_d_reg,   ext_d_next;
    lpm_state_e                      state_reg,  state_next;
    logic [`LPM_BOOT_W-1:0]          boot_reg,   boot_next;
    logic                            det_fall;
    logic                            det_rise;
    logic                            wake_rise;
    logic [`LPM_EXT_LINES-1:0]       ext_rise;
    logic                            stop_wake;
    logic                            stdby_wake;
    logic                            any_event;
    logic                            woke_stop;
    logic                            woke_stdby;
    logic                            det_on;

    // Reset pin and watchdog act as hard reset causes beside the supervisor
    assign det_on    = ctrl_reg[`LPM_CTRL_DET_EN];
    assign det_fall  = det_on && above_d_reg && !above_s;
    assign det_rise  = det_on && !above_d_reg && above_s;
    assign wake_rise = wake_s && !wake_d_reg;
    assign ext_rise  = ext_s & ~ext_d_reg & wakeen_reg;

    assign stop_wake  = (|ext_rise) || alarm_s || det_fall || det_rise;
    assign stdby_wake = !pin_n_s || wdg_s || wake_rise || alarm_s;
    assign any_event  = core_event || stop_wake || irq;

    always_comb begin
        state_next = state_reg;
        boot_next  = boot_reg;
        woke_stop  = 1'b0;
        woke_stdby = 1'b0;
        case (state_reg)
            LPM_BOOT: begin
                if (boot_reg == `LPM_BOOT_W'(`LPM_BOOT_CYC - 1)) begin
                    state_next = LPM_RUN;
                end else begin
                    boot_next = boot_reg + `LPM_BOOT_W'(1);
                end
            end
            LPM_RUN: begin
                if (wait_req) begin
                    if (!ctrl_reg[`LPM_CTRL_DEEP]) begin
                        state_next = LPM_SLEEP;
                    end else if (ctrl_reg[`LPM_CTRL_STDBY]) begin
                        state_next = LPM_STANDBY;
                    end else begin
                        state_next = LPM_STOP;
                    end
                end
            end
            LPM_SLEEP: begin
                if (any_event) begin
                    state_next = LPM_RUN;
                end
            end
            LPM_STOP: begin
                if (stop_wake) begin
                    state_next = LPM_RUN;
                    woke_stop  = 1'b1;
                end
            end
            LPM_STANDBY: begin
                if (stdby_wake) begin
                    state_next = LPM_BOOT;
                    boot_next  = '0;
                    woke_stdby = 1'b1;
                end
            end
            default: begin
                state_next = LPM_BOOT;
                boot_next  = '0;
            end
        endcase
        if (!por_ok || !pin_n_s || wdg_s) begin
            state_next = LPM_BOOT;
            boot_next  = '0;
        end
    end

    always_comb begin
        ctrl_next   = ctrl_reg;
        mask_next   = mask_reg;
        wakeen_next = wakeen_reg;
        status_next = status_reg;
        rdata_next  = '0;
        above_d_next = above_s;
        wake_d_next  = wake_s;
        ext_d_next   = ext_s;
        if (wr) begin
            case (addr)
                `LPM_OFF_CTRL:   ctrl_next   = wdata[`LPM_CTRL_W-1:0];
                `LPM_OFF_MASK:   mask_next   = wdata[`LPM_ST_W-1:0];
                `LPM_OFF_WAKEEN: wakeen_next = wdata[`LPM_EXT_LINES-1:0];
                `LPM_OFF_STATUS: status_next = status_reg & ~wdata[`LPM_ST_W-1:0];
                default: ;
            endcase
        end
        // Set wins over clear
        if (det_fall && ctrl_reg[`LPM_CTRL_FALL]) status_next[`LPM_ST_DET_FALL] = 1'b1;
        if (det_rise && ctrl_reg[`LPM_CTRL_RISE]) status_next[`LPM_ST_DET_RISE] = 1'b1;
        if (woke_stop)  status_next[`LPM_ST_WOKE_STOP]  = 1'b1;
        if (woke_stdby) status_next[`LPM_ST_WOKE_STDBY] = 1'b1;
        if (woke_stdby) begin
            ctrl_next   = `LPM_CTRL_RST;
            mask_next   = `LPM_ST_RST;
            wakeen_next = `LPM_WAKEEN_RST;
        end
        if (rd) begin
            case (addr)
                `LPM_OFF_CTRL:   rdata_next = `LPM_DATA_W'(ctrl_reg);
                `LPM_OFF_STATUS: rdata_next = `LPM_DATA_W'(status_reg);
                `LPM_OFF_MASK:   rdata_next = `LPM_DATA_W'(mask_reg);
                `LPM_OFF_STATE:  rdata_next = `LPM_DATA_W'(state_reg);
                `LPM_OFF_WAKEEN: rdata_next = `LPM_DATA_W'(wakeen_reg);
                default:         rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_reg   <= LPM_BOOT;
            boot_reg    <= '0;
            ctrl_reg    <= `LPM_CTRL_RST;
            status_reg  <= `LPM_ST_RST;
            mask_reg    <= `LPM_ST_RST;
            wakeen_reg  <= `LPM_WAKEEN_RST;
            rdata       <= '0;
            above_d_reg <= 1'b0;
            wake_d_reg  <= 1'b0;
            ext_d_reg   <= '0;
        end else begin
            state_reg   <= state_next;
            boot_reg    <= boot_next;
            ctrl_reg    <= ctrl_next;
            status_reg  <= status_next;
            mask_reg    <= mask_next;
            wakeen_reg  <= wakeen_next;
            rdata       <= rdata_next;
            above_d_reg <= above_d_next;
            wake_d_reg  <= wake_d_next;
            ext_d_reg   <= ext_d_next;
        end
    end

    assign irq = |(status_reg & mask_reg);

    always_comb begin
        power.core_rst_n    = (state_reg != LPM_BOOT) && (state_reg != LPM_STANDBY);
        power.core_clk_en   = (state_reg == LPM_RUN);
        power.periph_clk_en = (state_reg == LPM_RUN) || (state_reg == LPM_SLEEP);
        power.fast_osc_en   = (state_reg != LPM_STOP) && (state_reg != LPM_STANDBY);
        case (state_reg)
            LPM_STOP:    power.reg_mode = ctrl_reg[`LPM_CTRL_STOP_LP] ? LPM_REG_LOW : LPM_REG_MAIN;
            LPM_STANDBY: power.reg_mode = LPM_REG_OFF;
            default:     power.reg_mode = LPM_REG_MAIN;
        endcase
    end

    assign slow_domain_en = 1'b1;

    property p_boot_after_reset;
        @(posedge clock) disable iff (!rstn)
        (!por_ok) |=> (state_reg == LPM_BOOT);
    endproperty
    a_boot_after_reset: assert property (p_boot_after_reset)
        else $error("supply low did not force boot");

    property p_boot_core_held;
        @(posedge clock) disable iff (!rstn)
        (state_reg == LPM_BOOT) |-> (!power.core_rst_n && power.reg_mode == LPM_REG_MAIN);
    endproperty
    a_boot_core_held: assert property (p_boot_core_held)
        else $error("core not held in reset during boot");

    property p_boot_holds;
        @(posedge clock) disable iff (!rstn)
        (state_reg == LPM_BOOT && boot_reg != `LPM_BOOT_W'(`LPM_BOOT_CYC - 1)) |=> (state_reg == LPM_BOOT);
    endproperty
    a_boot_holds: assert property (p_boot_holds)
        else $error("boot sequence cut short");

    property p_no_det_off;
        @(posedge clock) disable iff (!rstn)
        (!det_on) |=> (!$rose(status_reg[`LPM_ST_DET_FALL]) && !$rose(status_reg[`LPM_ST_DET_RISE]));
    endproperty
    a_no_det_off: assert property (p_no_det_off)
        else $error("detector flag set while disabled");

    property p_det_fall_flag;
        @(posedge clock) disable iff (!rstn)
        (det_fall && ctrl_reg[`LPM_CTRL_FALL]) |=> status_reg[`LPM_ST_DET_FALL];
    endproperty
    a_det_fall_flag: assert property (p_det_fall_flag)
        else $error("falling crossing not flagged");

    property p_det_rise_flag;
        @(posedge clock) disable iff (!rstn)
        (det_rise && ctrl_reg[`LPM_CTRL_RISE]) |=> status_reg[`LPM_ST_DET_RISE];
    endproperty
    a_det_rise_flag: assert property (p_det_rise_flag)
        else $error("rising crossing not flagged");

    property p_det_fall_off;
        @(posedge clock) disable iff (!rstn)
        (!ctrl_reg[`LPM_CTRL_FALL] && !status_reg[`LPM_ST_DET_FALL]) |=> !status_reg[`LPM_ST_DET_FALL];
    endproperty
    a_det_fall_off: assert property (p_det_fall_off)
        else $error("falling flag set while its edge is off");

    property p_run_power;
        @(posedge clock) disable iff (!rstn)
        (state_reg == LPM_RUN) |-> (power.reg_mode == LPM_REG_MAIN && power.core_rst_n && power.core_clk_en);
    endproperty
    a_run_power: assert property (p_run_power)
        else $error("run not on main regulation");

    property p_stop_reg;
        @(posedge clock) disable iff (!rstn)
        (state_reg == LPM_STOP) |-> (power.reg_mode == (ctrl_reg[`LPM_CTRL_STOP_LP] ? LPM_REG_LOW : LPM_REG_MAIN));
    endproperty
    a_stop_reg: assert property (p_stop_reg)
        else $error("stop regulator mode wrong");

    property p_stdby_off;
        @(posedge clock) disable iff (!rstn)
        (state_reg == LPM_STANDBY) |-> (power.reg_mode == LPM_REG_OFF && !power.fast_osc_en && !power.core_rst_n);
    endproperty
    a_stdby_off: assert property (p_stdby_off)
        else $error("standby not powered down");

    property p_sleep_clk;
        @(posedge clock) disable iff (!rstn)
        (state_reg == LPM_SLEEP) |-> (!power.core_clk_en && power.periph_clk_en && power.fast_osc_en);
    endproperty
    a_sleep_clk: assert property (p_sleep_clk)
        else $error("sleep clocks wrong");

    property p_sleep_entry;
        @(posedge clock) disable iff (!rstn)
        (state_reg == LPM_RUN && wait_req && !ctrl_reg[`LPM_CTRL_DEEP] && por_ok && pin_n_s && !wdg_s)
            |=> (state_reg == LPM_SLEEP);
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("sleep not entered");

    property p_sleep_exit;
        @(posedge clock) disable iff (!rstn)
        (state_reg == LPM_SLEEP && core_event && por_ok && pin_n_s && !wdg_s) |=> (state_reg == LPM_RUN);
    endproperty
    a_sleep_exit: assert property (p_sleep_exit)
        else $error("event did not end sleep");

    property p_stop_clk;
        @(posedge clock) disable iff (!rstn)
        (state_reg == LPM_STOP) |-> (!power.core_clk_en && !power.periph_clk_en && !power.fast_osc_en
            && power.core_rst_n);
    endproperty
    a_stop_clk: assert property (p_stop_clk)
        else $error("stop clocks wrong");

    property p_stop_exit;
        @(posedge clock) disable iff (!rstn)
        (state_reg == LPM_STOP && stop_wake && por_ok && pin_n_s && !wdg_s) |=> (state_reg == LPM_RUN);
    endproperty
    a_stop_exit: assert property (p_stop_exit)
        else $error("stop did not exit");

    property p_stop_flag;
        @(posedge clock) disable iff (!rstn)
        woke_stop |=> status_reg[`LPM_ST_WOKE_STOP];
    endproperty
    a_stop_flag: assert property (p_stop_flag)
        else $error("stop wakeup not flagged");

    property p_stdby_exit;
        @(posedge clock) disable iff (!rstn)
        (state_reg == LPM_STANDBY && stdby_wake) |=> (state_reg == LPM_BOOT) ##1 (state_reg == LPM_BOOT);
    endproperty
    a_stdby_exit: assert property (p_stdby_exit)
        else $error("standby exit not through reset");

    property p_stdby_cfg;
        @(posedge clock) disable iff (!rstn)
        woke_stdby |=> (ctrl_reg == `LPM_CTRL_RST && wakeen_reg == `LPM_WAKEEN_RST);
    endproperty
    a_stdby_cfg: assert property (p_stdby_cfg)
        else $error("standby exit kept old settings");
endmodule : lpm_ctrl

//--- dv/lpm_far_side.sv
`timescale 1ns/100ps
module lpm_far_side
    import lpm_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        go,
    input  wire logic [2:0]  cmd,
    input  wire logic [3:0]  line,
    output logic      [15:0] ext_lines,
    output logic             alarm,
    output logic             wake_pin,
    output logic             reset_pin_n,
    output logic             wdog_rst,
    output logic             core_event
);
    logic [2:0] cnt_reg = 3'h0;
    logic [2:0] cmd_reg = 3'h0;
    logic       act;

    // Each source held 4 cycles so the input synchronisers see it
    always_ff @(posedge clock) begin
        if (go) begin
            cnt_reg <= 3'h4;
            cmd_reg <= cmd;
        end else if (cnt_reg != 3'h0) begin
            cnt_reg <= cnt_reg - 3'h1;
        end
    end
    assign act         = cnt_reg != 3'h0;
    assign ext_lines   = (act && cmd_reg == 3'h0) ? 16'h0001 << line : 16'h0000;
    assign alarm       = act && cmd_reg == 3'h1;
    assign wake_pin    = act && cmd_reg == 3'h2;
    assign reset_pin_n = !(act && cmd_reg == 3'h3);
    assign wdog_rst    = act && cmd_reg == 3'h4;
    assign core_event  = act && cmd_reg == 3'h5;
endmodule : lpm_far_side

//--- dv/low_power_mode_controller_bench.sv
`timescale 1ns/100ps
module low_power_mode_controller_bench
    import lpm_pkg::*;
;
    logic        clock, rstn, wr, rd, irq, supply_ok, above, wait_req, go, slow_domain_en;
    logic        alarm, wake_pin, reset_pin_n, wdog_rst, core_event;
    logic [3:0]  addr, line;
    logic [2:0]  cmd;
    logic [31:0] wdata, rdata;
    logic [15:0] ext_lines;
    lpm_power_s  power;
    logic [31:0] exp_q[$];
    logic        rd_seen = 1'b0;
    int          n_mismatch = 0;
    int          tests_run = 0;
    logic [2:0]  cmd_tab [4] = '{3'h2, 3'h1, 3'h3, 3'h4};

    lpm_ctrl u_dut (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq(irq), .supply_ok(supply_ok), .supply_above_threshold(above),
        .wait_req(wait_req), .core_event(core_event), .external_event_lines(ext_lines),
        .alarm(alarm), .wake_pin(wake_pin), .reset_pin_n(reset_pin_n),
        .independent_watchdog_rst(wdog_rst), .power(power), .slow_domain_en(slow_domain_en));
    lpm_far_side u_far (.clock(clock), .go(go), .cmd(cmd), .line(line), .ext_lines(ext_lines),
        .alarm(alarm), .wake_pin(wake_pin), .reset_pin_n(reset_pin_n), .wdog_rst(wdog_rst),
        .core_event(core_event));

    task automatic end_sim;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Read data answers one cycle after the strobe
    always @(posedge clock) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) begin
                chk(rdata, 32'hdead_beef);
            end else begin
                chk(rdata, exp_q.pop_front());
            end
        end
        rd_seen <= rd;
    end

    task automatic wt(input logic [5:0] exp, input logic [5:0] msk);
        int i;
        for (i = 0; i < 200 && ((power ^ exp) & msk) !== 6'h00; i++) begin
            @(posedge clock);
        end
        chk(32'(power & msk), 32'(exp & msk));
        if (i == 200) begin
            n_mismatch++;
            end_sim();
        end
    endtask : wt

    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [3:0] a, input logic [31:0] e);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock);
        rd   <= 1'b0;
    endtask : rreg

    task automatic fire(input logic [2:0] c);
        @(posedge clock);
        go  <= 1'b1;
        cmd <= c;
        @(posedge clock);
        go  <= 1'b0;
    endtask : fire

    task automatic enter;
        @(posedge clock);
        wait_req <= 1'b1;
        @(posedge clock);
        wait_req <= 1'b0;
    endtask : enter

    task automatic sup(input logic v);
        @(posedge clock);
        above <= v;
        repeat (8) @(posedge clock);
    endtask : sup

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    initial begin
        {rstn, wr, rd, wait_req, go, cmd, line, addr, wdata} <= '0;
        supply_ok <= 1'b1;
        above     <= 1'b1;
        void'($urandom(32206));
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        wt(6'h00, 6'h07);
        wt(6'h3c, 6'h3f);
        chk(32'(slow_domain_en), 32'h0000_0001);
        supply_ok <= 1'b0;
        wt(6'h00, 6'h07);
        supply_ok <= 1'b1;
        wt(6'h3c, 6'h3f);
        rreg(4'h0, 32'h0000_0000);
        rreg(4'h2, 32'h0000_0000);
        rreg(4'h3, 32'h0000_0000);
        rreg(4'h4, 32'h0000_ffff);
        rreg(4'(5 + $urandom % 11), 32'h0000_0000);
        sup(1'b0);
        sup(1'b1);
        rreg(4'h1, 32'h0000_0000);
        wreg(4'h0, 32'h0000_0007);
        wreg(4'h2, 32'h0000_0003);
        sup(1'b0);
        rreg(4'h1, 32'h0000_0001);
        chk(32'(irq), 32'h0000_0001);
        sup(1'b1);
        rreg(4'h1, 32'h0000_0003);
        wreg(4'h2, 32'h0000_0000);
        #1 chk(32'(irq), 32'h0000_0000);
        wreg(4'h1, 32'h0000_0003);
        wreg(4'h0, 32'h0000_0000);
        rreg(4'h1, 32'h0000_0000);
        enter();
        wt(6'h1c, 6'h3f);
        fire(3'h5);
        wt(6'h3c, 6'h3f);
        for (int k = 0; k < 4; k++) begin
            wreg(4'h0, 32'h0000_0010 | 32'(k % 2) << 3);
            line <= 4'($urandom % 16);
            enter();
            wt(6'h04 | 6'(k % 2), 6'h3f);
            chk(32'(slow_domain_en), 32'h0000_0001);
            fire(k < 2 ? 3'h0 : 3'h1);
            wt(6'h3c, 6'h3f);
            rreg(4'h1, 32'h0000_0004);
            wreg(4'h1, 32'h0000_000f);
        end
        foreach (cmd_tab[k]) begin
            wreg(4'h0, 32'h0000_0030);
            enter();
            wt(6'h02, 6'h3f);
            chk(32'(slow_domain_en), 32'h0000_0001);
            fire(cmd_tab[k]);
            wt(6'h00, 6'h07);
            wt(6'h3c, 6'h3f);
            rreg(4'h0, 32'h0000_0000);
            rreg(4'h1, 32'h0000_0008);
            wreg(4'h1, 32'h0000_000f);
        end
        repeat (4) @(posedge clock);
        end_sim();
    end
endmodule : low_power_mode_controller_bench
